/* File: pkg/arcu_pkg.sv */
// Shared constants for the converter result compute unit.
`default_nettype none
package arcu_pkg;
    localparam int RES_W = 10;
    localparam int BYTE_W = 8;
    localparam int ACC_W = 18;
    localparam int CNT_W = 8;
    localparam int SHIFT_W = 3;
    localparam int MODE_W = 3;
    localparam int LJ_PAD = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [MODE_W-1:0] MODE_BASIC = 3'h0;
    localparam logic [MODE_W-1:0] MODE_ACCUM = 3'h1;
    localparam logic [MODE_W-1:0] MODE_AVG = 3'h2;
    localparam logic [MODE_W-1:0] MODE_BURST = 3'h3;
    localparam logic [MODE_W-1:0] MODE_LPF = 3'h4;
    localparam logic JUSTIFY_LEFT = 1'b0;
    typedef enum logic [0:0] {ST_IDLE, ST_BUSY} arcu_state_t;
endpackage
`default_nettype wire

/* File: rtl/arcu_compute.sv */
// Converter result compute unit: flag, wake, formatting and computation engine.
`timescale 1ns/100ps
`default_nettype none
module arcu_compute (
    input wire logic clk,
    input wire logic reset,
    input wire logic conversionGoSet,
    input wire logic retrigger,
    input wire logic accumClearCmd,
    input wire logic convDoneFlagClear,
    input wire logic convDoneIrqEnable,
    input wire logic sleepMode,
    input wire logic dedicatedRcOscSel,
    input wire logic [arcu_pkg::MODE_W-1:0] computeModeSel,
    input wire logic [arcu_pkg::SHIFT_W-1:0] divideShiftSel,
    input wire logic doubleSampleEnable,
    input wire logic resultJustifySel,
    input wire logic [arcu_pkg::CNT_W-1:0] repeatTarget,
    input wire logic convDone,
    input wire logic [arcu_pkg::RES_W-1:0] convData,
    input wire logic resultLowWrite,
    input wire logic resultHighWrite,
    input wire logic [arcu_pkg::BYTE_W-1:0] resultWriteData,
    output logic startConversion,
    output logic conversionGo,
    output logic convDoneFlag,
    output logic wakeRequest,
    output logic [arcu_pkg::BYTE_W-1:0] convResultHigh,
    output logic [arcu_pkg::BYTE_W-1:0] convResultLow,
    output logic [arcu_pkg::RES_W-1:0] previousResult,
    output logic [arcu_pkg::ACC_W-1:0] sumAccumulator,
    output logic [arcu_pkg::CNT_W-1:0] sampleCounter,
    output logic [arcu_pkg::ACC_W-1:0] filterOutput,
    output logic accumOverflowFlag
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Signed shift that rounds toward zero; a plain arithmetic shift would floor negatives.
    function automatic logic signed [arcu_pkg::ACC_W-1:0] divTrunc(
        input logic signed [arcu_pkg::ACC_W-1:0] a,
        input logic [arcu_pkg::SHIFT_W-1:0] sh
    );
        logic signed [arcu_pkg::ACC_W-1:0] bias;
        bias = (a < 0) ? ((arcu_pkg::ACC_W'(1) <<< sh) - arcu_pkg::ACC_W'(1))
                       : arcu_pkg::ACC_W'(0);
        return (a + bias) >>> sh;
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    arcu_pkg::arcu_state_t state, next_state;
    logic [arcu_pkg::RES_W-1:0] resultValue, next_resultValue;
    logic [arcu_pkg::RES_W-1:0] next_previousResult;
    logic signed [arcu_pkg::ACC_W-1:0] acc, next_acc;
    logic [arcu_pkg::CNT_W-1:0] cnt, next_cnt;
    logic next_convDoneFlag, next_wakeRequest, next_startConversion, next_overflow;
    logic canRun, goEvent, doneTaken, atTarget;
    logic signed [arcu_pkg::ACC_W-1:0] sample, sum, filtSum;
    logic addOvf;

    // The converter may not run in sleep unless clocked by the dedicated RC oscillator.
    assign canRun = !sleepMode || dedicatedRcOscSel;
    assign goEvent = conversionGoSet || retrigger;
    assign doneTaken = convDone && (state == arcu_pkg::ST_BUSY) && canRun;
    assign atTarget = cnt >= repeatTarget;

    // Sample selection and the adders shared by all accumulating modes.
    // The result register still holds the previous conversion here, so it is the subtrahend.
    always_comb begin
        if (doubleSampleEnable) begin
            sample = arcu_pkg::ACC_W'(signed'({1'b0, convData}))
                   - arcu_pkg::ACC_W'(signed'({1'b0, resultValue}));
        end else begin
            sample = arcu_pkg::ACC_W'(signed'({1'b0, convData}));
        end
        sum = acc + sample;
        addOvf = (acc[arcu_pkg::ACC_W-1] == sample[arcu_pkg::ACC_W-1])
              && (sum[arcu_pkg::ACC_W-1] != acc[arcu_pkg::ACC_W-1]);
        filtSum = sum - divTrunc(acc, divideShiftSel);
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // Clears are applied first, then a completed conversion updates the engine.
    always_comb begin
        next_state = state;
        next_resultValue = resultValue;
        next_previousResult = previousResult;
        next_acc = acc;
        next_cnt = cnt;
        next_overflow = accumOverflowFlag;
        next_startConversion = 1'b0;
        next_wakeRequest = 1'b0;
        next_convDoneFlag = convDoneFlag;
        if (convDoneFlagClear) begin
            next_convDoneFlag = 1'b0;
        end
        // Software writes land right justified; format only affects the read view.
        if (resultLowWrite) begin
            next_resultValue[arcu_pkg::BYTE_W-1:0] = resultWriteData;
        end
        if (resultHighWrite) begin
            next_resultValue[arcu_pkg::RES_W-1:arcu_pkg::BYTE_W] =
                resultWriteData[arcu_pkg::RES_W-arcu_pkg::BYTE_W-1:0];
        end
        if (accumClearCmd) begin
            next_acc = '0;
            next_cnt = '0;
            next_overflow = 1'b0;
        end
        if (goEvent && canRun && state == arcu_pkg::ST_IDLE) begin
            if ((computeModeSel == arcu_pkg::MODE_AVG && atTarget)
                || computeModeSel == arcu_pkg::MODE_BURST) begin
                next_acc = '0;
                next_cnt = '0;
            end
            next_state = arcu_pkg::ST_BUSY;
            next_startConversion = 1'b1;
        end
        if (state == arcu_pkg::ST_BUSY && !canRun) begin
            next_state = arcu_pkg::ST_IDLE;
        end
        if (doneTaken) begin
            next_convDoneFlag = 1'b1;
            next_wakeRequest = sleepMode && convDoneIrqEnable;
            next_previousResult = resultValue;
            next_resultValue = convData;
            next_state = arcu_pkg::ST_IDLE;
            unique case (computeModeSel)
                arcu_pkg::MODE_ACCUM: begin
                    next_acc = sum;
                    next_overflow = accumOverflowFlag || addOvf;
                    next_cnt = (cnt == arcu_pkg::CNT_MAX) ? cnt : cnt + 1'b1;
                end
                arcu_pkg::MODE_AVG, arcu_pkg::MODE_BURST: begin
                    next_acc = sum;
                    next_overflow = accumOverflowFlag || addOvf;
                    next_cnt = atTarget ? arcu_pkg::CNT_ONE : cnt + 1'b1;
                    if (computeModeSel == arcu_pkg::MODE_BURST && !atTarget
                        && (cnt + 1'b1) < repeatTarget) begin
                        next_state = arcu_pkg::ST_BUSY;
                        next_startConversion = 1'b1;
                    end
                end
                arcu_pkg::MODE_LPF: begin
                    next_acc = filtSum;
                    next_overflow = accumOverflowFlag || addOvf;
                    next_cnt = (cnt == arcu_pkg::CNT_MAX) ? cnt : cnt + 1'b1;
                end
                default: begin
                    next_acc = acc;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= arcu_pkg::ST_IDLE;
            resultValue <= '0;
            previousResult <= '0;
            acc <= '0;
            cnt <= '0;
            accumOverflowFlag <= 1'b0;
            startConversion <= 1'b0;
            wakeRequest <= 1'b0;
            convDoneFlag <= 1'b0;
        end else begin
            state <= next_state;
            resultValue <= next_resultValue;
            previousResult <= next_previousResult;
            acc <= next_acc;
            cnt <= next_cnt;
            accumOverflowFlag <= next_overflow;
            startConversion <= next_startConversion;
            wakeRequest <= next_wakeRequest;
            convDoneFlag <= next_convDoneFlag;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign conversionGo = (state == arcu_pkg::ST_BUSY);
    assign sumAccumulator = acc;
    assign sampleCounter = cnt;
    // The filter view is combinational from the accumulator flop to avoid a second copy.
    assign filterOutput = divTrunc(acc, divideShiftSel);

    arcu_justify u_justify (
        .value(resultValue),
        .justifySel(resultJustifySel),
        .highByte(convResultHigh),
        .lowByte(convResultLow)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Each property samples on the rising edge and is off while reset is high.
    // They watch internal nets, so they sit here rather than in a separate checker.
    flag_set_a: assert property (doneTaken |=> convDoneFlag)
        else $error("Done flag not set after a completed conversion.");
    flag_hold_a: assert property ($fell(convDoneFlag) |-> $past(convDoneFlagClear))
        else $error("Done flag cleared without software clear.");
    wake_on_done_a: assert property (doneTaken && sleepMode && convDoneIrqEnable
        |=> wakeRequest && convDoneFlag)
        else $error("No wake after conversion in sleep.");
    sleep_block_a: assert property (sleepMode && !dedicatedRcOscSel |=> !startConversion)
        else $error("Conversion started in sleep without RC clock.");
    busy_drop_a: assert property (conversionGo && sleepMode && !dedicatedRcOscSel
        |=> !conversionGo)
        else $error("Busy state kept in sleep without RC clock.");
    right_view_a: assert property (doneTaken && resultJustifySel && !resultLowWrite
        && !resultHighWrite ##1 resultJustifySel
        |-> convResultLow == $past(convData[arcu_pkg::BYTE_W-1:0]))
        else $error("Right justified result mismatch.");
    left_view_a: assert property (doneTaken && !resultJustifySel && !resultLowWrite
        && !resultHighWrite ##1 !resultJustifySel |-> convResultHigh
        == $past(convData[arcu_pkg::RES_W-1:arcu_pkg::RES_W-arcu_pkg::BYTE_W]))
        else $error("Left justified result mismatch.");
    write_store_a: assert property (resultLowWrite && !doneTaken && !resultJustifySel
        ##1 !resultJustifySel |-> convResultHigh[arcu_pkg::LJ_PAD-1:0]
        == $past(resultWriteData[arcu_pkg::BYTE_W-1:arcu_pkg::BYTE_W-arcu_pkg::LJ_PAD]))
        else $error("Software write not stored right justified.");
    sat_count_a: assert property (doneTaken && !accumClearCmd && cnt == arcu_pkg::CNT_MAX
        && (computeModeSel == arcu_pkg::MODE_ACCUM || computeModeSel == arcu_pkg::MODE_LPF)
        |=> cnt == arcu_pkg::CNT_MAX)
        else $error("Sample counter wrapped.");
    avg_reload_a: assert property (doneTaken && !accumClearCmd && atTarget
        && computeModeSel == arcu_pkg::MODE_AVG |=> cnt == arcu_pkg::CNT_ONE)
        else $error("Average counter did not reload.");
    clear_cmd_a: assert property (accumClearCmd && !doneTaken && !goEvent
        |=> acc == 0 && cnt == 0)
        else $error("Clear command did not clear.");
    avg_go_clear_a: assert property (goEvent && canRun && state == arcu_pkg::ST_IDLE
        && computeModeSel == arcu_pkg::MODE_AVG && atTarget |=> acc == 0 && cnt == 0)
        else $error("Average go at target did not clear.");
    burst_go_a: assert property (conversionGoSet && canRun && state == arcu_pkg::ST_IDLE
        && !doneTaken && computeModeSel == arcu_pkg::MODE_BURST
        |=> cnt == 0 && acc == 0 && startConversion)
        else $error("Burst go did not clear and start.");
    burst_repeat_a: assert property (doneTaken && !accumClearCmd
        && computeModeSel == arcu_pkg::MODE_BURST && (cnt + 9'h001) < repeatTarget
        |=> startConversion && conversionGo)
        else $error("Burst did not repeat.");
    burst_end_a: assert property (doneTaken && computeModeSel == arcu_pkg::MODE_BURST
        && !atTarget && (cnt + 9'h001) >= repeatTarget
        |=> !conversionGo && cnt == $past(repeatTarget))
        else $error("Burst did not stop at the target.");
    go_refused_a: assert property (conversionGo && !doneTaken |=> !startConversion)
        else $error("Conversion started while busy.");
    lpf_update_a: assert property (doneTaken && !accumClearCmd
        && computeModeSel == arcu_pkg::MODE_LPF |=> acc == $past(filtSum))
        else $error("Low-pass update wrong.");
    dse_sample_a: assert property (doubleSampleEnable && convData == resultValue
        |-> sample == 0)
        else $error("Double sample difference wrong.");
    // Truncation keeps the quotient times the divisor between the dividend and zero.
    trunc_div_a: assert property (acc < 0
        |-> $signed(filterOutput) <= 0 && ($signed(filterOutput) <<< divideShiftSel) >= acc)
        else $error("Division did not truncate toward zero.");

    // ---------------------------------------------------------------
    // Cover points
    // ---------------------------------------------------------------
    burst_seen_c: cover property (computeModeSel == arcu_pkg::MODE_BURST && doneTaken
        ##1 startConversion);
    wake_seen_c: cover property (wakeRequest);
    lpf_seen_c: cover property (computeModeSel == arcu_pkg::MODE_LPF && doneTaken);
    avg_restart_c: cover property (computeModeSel == arcu_pkg::MODE_AVG && goEvent && atTarget
        && state == arcu_pkg::ST_IDLE);
    sleep_drop_c: cover property (conversionGo && sleepMode && !dedicatedRcOscSel);
endmodule
`default_nettype wire

/* File: rtl/arcu_justify.sv */
// Result pair formatter: places the stored 10-bit value left or right justified.
`timescale 1ns/100ps
`default_nettype none
module arcu_justify (
    input wire logic [arcu_pkg::RES_W-1:0] value,
    input wire logic justifySel,
    output logic [arcu_pkg::BYTE_W-1:0] highByte,
    output logic [arcu_pkg::BYTE_W-1:0] lowByte
);
    // ---------------------------------------------------------------
    // Formatting
    // ---------------------------------------------------------------
    // Left justified puts the top eight bits high and pads the low byte with zeros.
    always_comb begin
        if (justifySel == arcu_pkg::JUSTIFY_LEFT) begin
            highByte = value[arcu_pkg::RES_W-1:arcu_pkg::RES_W-arcu_pkg::BYTE_W];
            lowByte = {value[arcu_pkg::RES_W-arcu_pkg::BYTE_W-1:0],
                       {arcu_pkg::LJ_PAD{1'b0}}};
        end else begin
            highByte = {{arcu_pkg::LJ_PAD{1'b0}}, value[arcu_pkg::RES_W-1:arcu_pkg::BYTE_W]};
            lowByte = value[arcu_pkg::BYTE_W-1:0];
        end
    end
endmodule
`default_nettype wire

/* File: sim/arcu_core_model.sv */
// Behavioural model of the analog converter core that answers start requests.
`timescale 1ns/100ps
`default_nettype none
module arcu_core_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic startConversion,
    input wire logic [3:0] latency,
    input wire logic [arcu_pkg::RES_W-1:0] sample,
    output logic convDone,
    output logic [arcu_pkg::RES_W-1:0] convData
);
    logic [3:0] remaining;
    logic [arcu_pkg::RES_W-1:0] lastData;
    // Counts the conversion time down and presents the sample for one cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            remaining <= 4'h0;
            convDone <= 1'b0;
            lastData <= 10'h000;
        end else begin
            convDone <= 1'b0;
            if (startConversion) begin
                remaining <= latency;
            end else if (remaining == 4'h1) begin
                remaining <= 4'h0;
                convDone <= 1'b1;
                lastData <= sample;
            end else if (remaining != 4'h0) begin
                remaining <= remaining - 4'h1;
            end
        end
    end
    // Outside the done cycle the bus shows the inverse, so late sampling cannot match by luck.
    assign convData = convDone ? lastData : ~lastData;
endmodule
`default_nettype wire

/* File: sim/test_arcu_compute.sv */
// Self-checking testbench for the converter result compute unit.
`timescale 1ns/100ps
`default_nettype none
module test_arcu_compute;
    logic clk = 0, reset = 1, goSet = 0, retrig = 0, clr = 0, flagClr = 0, irqEn = 0;
    logic sleep = 0, rcSel = 0, dse = 0, just = 0, done, lowWr = 0, highWr = 0;
    logic [2:0] mode = 3'h0, shift = 3'h0;
    logic [7:0] target = 8'h00, wrData = 8'h00, resHigh, resLow, cnt;
    logic [9:0] sample = 10'h000, data, prev;
    logic [3:0] lat = 4'h1;
    logic startConv, busy, flag, wake, ovf;
    logic [17:0] acc, filt;
    int n_fail = 0, checks_done = 0, wakeSeen = 0;
    arcu_compute arcu_compute_inst (.clk(clk), .reset(reset), .conversionGoSet(goSet),
        .retrigger(retrig), .accumClearCmd(clr), .convDoneFlagClear(flagClr),
        .convDoneIrqEnable(irqEn), .sleepMode(sleep), .dedicatedRcOscSel(rcSel),
        .computeModeSel(mode), .divideShiftSel(shift), .doubleSampleEnable(dse),
        .resultJustifySel(just), .repeatTarget(target), .convDone(done), .convData(data),
        .resultLowWrite(lowWr), .resultHighWrite(highWr), .resultWriteData(wrData),
        .startConversion(startConv), .conversionGo(busy), .convDoneFlag(flag),
        .wakeRequest(wake), .convResultHigh(resHigh), .convResultLow(resLow),
        .previousResult(prev), .sumAccumulator(acc), .sampleCounter(cnt),
        .filterOutput(filt), .accumOverflowFlag(ovf));
    arcu_core_model arcu_core_model_inst (.clk(clk), .reset(reset), .startConversion(startConv),
        .latency(lat), .sample(sample), .convDone(done), .convData(data));
    // Free-running 50 MHz clock.
    initial begin
        forever #10 clk = ~clk;
    end
    // Wake pulses are counted at the falling edge, where they have settled.
    always @(negedge clk) begin
        if (wake === 1'b1) wakeSeen++;
    end
    task finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task check(input logic [17:0] got, input logic [17:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One go request, then wait, bounded, until the block is idle again.
    task convert(input logic [9:0] v, input logic useRetrigger);
        sample = v;
        if (useRetrigger) retrig = 1; else goSet = 1;
        @(negedge clk);
        retrig = 0;
        goSet = 0;
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
        if (busy !== 1'b0) check(18'h1, 18'h0, "conversion hang");
    endtask
    task pulseClear();
        clr = 1;
        @(negedge clk);
        clr = 0;
    endtask
    // Watchdog sized well above the few thousand cycles the sequence needs.
    initial begin
        #(20000 * 20);
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (6) @(negedge clk);
        reset = 0;
        check({busy, flag, resHigh, resLow}, 18'h0, "reset state");
        // Basic conversion with the interrupt disabled, seen in both formats.
        lat = 4'h6;
        convert(10'h2a5, 0);
        check(flag, 1, "done flag");
        check({resHigh, resLow}, 16'ha940, "left view");
        just = 1;
        #1 check({resHigh, resLow}, 16'h02a5, "right view");
        repeat (5) @(negedge clk);
        check(flag, 1, "flag holds");
        flagClr = 1;
        @(negedge clk);
        flagClr = 0;
        check(flag, 0, "flag cleared");
        // Software writes land right justified whatever the format.
        just = 0;
        wrData = 8'h02;
        highWr = 1;
        @(negedge clk);
        highWr = 0;
        wrData = 8'hff;
        lowWr = 1;
        @(negedge clk);
        lowWr = 0;
        check({resHigh, resLow}, 16'hbfc0, "written left");
        // Accumulate saturates the counter at FF.
        lat = 4'h1;
        mode = 3'h1;
        pulseClear();
        for (int i = 0; i < 256; i++) convert(10'h001, i[0]);
        check(cnt, 8'hff, "count saturates");
        check(acc, 18'h00100, "accumulated sum");
        // Double sampling: 0 minus previous 1 gives -1; -1/4 truncates to 0.
        dse = 1;
        shift = 3'h2;
        pulseClear();
        convert(10'h000, 0);
        check(acc, 18'h3ffff, "difference sample");
        check(filt, 18'h0, "truncated division");
        convert(10'h009, 0);
        check({acc[9:0], filt[7:0]}, {10'h008, 8'h02}, "second difference");
        dse = 0;
        // Average clears the sum and counter at a go once the count reaches the target.
        mode = 3'h2;
        target = 8'h02;
        pulseClear();
        convert(10'h00a, 0);
        convert(10'h014, 0);
        check({acc[9:0], cnt}, {10'h01e, 8'h02}, "average sum");
        check(prev, 18'h0000a, "previous result");
        convert(10'h007, 1);
        check({acc[9:0], cnt}, {10'h007, 8'h01}, "average restart");
        // Burst clears the old sum on go and repeats until the target.
        mode = 3'h3;
        target = 8'h03;
        lat = 4'h3;
        convert(10'h004, 0);
        check({acc[9:0], cnt}, {10'h00c, 8'h03}, "burst sum");
        // Low-pass: 5, then 5+5-5/2 = 8, filter 8/2 = 4.
        mode = 3'h4;
        shift = 3'h1;
        pulseClear();
        convert(10'h005, 0);
        convert(10'h005, 0);
        check({acc[9:0], cnt}, {10'h008, 8'h02}, "lowpass state");
        check(filt, 18'h4, "filter output");
        // A reset in mid-run must clear the engine state and the result pair.
        reset = 1;
        @(negedge clk);
        reset = 0;
        check({busy, flag, resHigh, resLow}, 18'h0, "second reset state");
        check({cnt, prev}, 18'h0, "second reset counters");
        check(acc, 18'h0, "second reset sum");
        // A long run of full-scale samples overflows the signed sum; clear drops the flag.
        mode = 3'h1;
        pulseClear();
        for (int i = 0; i < 129; i++) convert(10'h3ff, 0);
        check(ovf, 1, "sum overflow");
        pulseClear();
        check(ovf, 0, "overflow cleared");
        // Sleep without the RC clock refuses to start; with it, done wakes the part.
        mode = 3'h0;
        flagClr = 1;
        @(negedge clk);
        flagClr = 0;
        sleep = 1;
        irqEn = 1;
        convert(10'h001, 0);
        check({busy, flag, 8'(wakeSeen)}, 0, "no sleep run");
        rcSel = 1;
        convert(10'h001, 0);
        @(negedge clk);
        check({flag, 8'(wakeSeen)}, {1'b1, 8'h01}, "wake on done");
        irqEn = 0;
        convert(10'h001, 0);
        @(negedge clk);
        check(8'(wakeSeen), 8'h01, "no wake masked");
        // Losing the RC clock in sleep drops the busy state and a late done is ignored.
        sample = 10'h155;
        goSet = 1;
        @(negedge clk);
        goSet = 0;
        rcSel = 0;
        repeat (10) @(negedge clk);
        check({busy, resHigh, resLow}, 18'h00040, "sleep drop");
        finish_test();
    end
endmodule
`default_nettype wire
